// ### rtl/i2c_sram_pkg.sv
// constants, types and states shared by the two-wire sram slave
`default_nettype none

package i2c_sram_pkg;

  // ***********************************************************
  // memory and byte shape
  // ***********************************************************
  localparam int unsigned MEM_DEPTH   = 256;     // words of storage
  localparam int unsigned MEM_AW      = 8;       // word address width
  localparam logic [3:0]  BYTE_BITS   = 4'h8;    // data bits per byte
  localparam logic [3:0]  DEV_TYPE    = 4'h6;    // arbitrary device-type code
  localparam logic [7:0]  ADDR_RST    = 8'h00;   // word address after reset
  localparam logic [7:0]  DATA_RST    = 8'h00;   // shift and transmit reset

  // ***********************************************************
  // buffering and pin sampling
  // ***********************************************************
  localparam int unsigned FIFO_DEPTH  = 32;      // pending write words
  localparam int unsigned SYNC_STAGES = 2;       // flops per pin
  localparam int unsigned PIN_W       = 6;       // sampled pin count
  localparam logic [5:0]  PIN_RST     = 6'h03;   // scl and sda idle high

  // bus sequencer states
  typedef enum logic [2:0] {
    st_idle, st_addr, st_word, st_wdata, st_rdata, st_ignore
  } bus_state_e;

  // one pending memory write
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } wr_req_s;

  // sampled pins, as one bundle through the synchroniser
  typedef struct packed {
    logic       saving;
    logic [2:0] hw_addr;
    logic       sda;
    logic       scl;
  } pins_s;

endpackage

`default_nettype wire

// ### rtl/pin_sync.sv
// multi-bit two-flop synchroniser for asynchronous pins
`default_nettype none

module pin_sync
  import i2c_sram_pkg::*;
#(
  parameter int unsigned      WIDTH   = 1,
  parameter int unsigned      STAGES  = SYNC_STAGES,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // pins in, sampled levels out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  // fewer than two stages would let metastability through
  if (STAGES < 2) begin : g_chk
    $error("pin_sync needs at least two stages");
  end

  logic [WIDTH-1:0] stage_r [STAGES];  // flop chain, stage 0 first

  // each stage reads only the one before it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < STAGES; i++) stage_r[i] <= RST_VAL;
    end else begin
      stage_r[0] <= d;
      for (int i = 1; i < STAGES; i++) stage_r[i] <= stage_r[i-1];
    end
  end

  assign q = stage_r[STAGES-1];

endmodule

`default_nettype wire

// ### rtl/byte_fifo.sv
// first-in first-out buffer with valid and ready on both sides
`default_nettype none

module byte_fifo
  import i2c_sram_pkg::*;
#(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  // pointer wrap trick needs a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("byte_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] store_r [DEPTH];  // word storage
  logic [AW:0]      wr_ptr_r;         // extra bit tells full from empty
  logic [AW:0]      rd_ptr_r;
  logic [AW:0]      fill;             // words held

  assign fill      = wr_ptr_r - rd_ptr_r;
  assign in_ready  = fill != (AW+1)'(DEPTH);
  assign out_valid = fill != '0;
  assign out_data  = store_r[rd_ptr_r[AW-1:0]];

  // pointers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (in_valid && in_ready) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (out_valid && out_ready) rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

  // storage carries no reset; empty words are never read out
  always_ff @(posedge clk) begin
    if (in_valid && in_ready) store_r[wr_ptr_r[AW-1:0]] <= in_data;
  end

endmodule

`default_nettype wire

// ### rtl/i2c_slave_sram_port.sv
// two-wire serial slave port in front of a 256 x 8 static memory
`default_nettype none

module i2c_slave_sram_port
  import i2c_sram_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // serial bus
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_n,
  // address straps
  input  wire logic hw_addr_bit_zero,
  input  wire logic hw_addr_bit_one,
  input  wire logic hw_addr_bit_two,
  // power saving
  input  wire logic power_save,
  output logic      saving
);

  // ***********************************************************
  // pin sampling
  // ***********************************************************

  pins_s      pin_raw;   // pins before sampling
  pins_s      pin_s;     // pins after two flops
  logic       scl_q_r;   // sampled clock, one cycle older
  logic       sda_q_r;   // sampled data, one cycle older
  logic       ps;        // power-saving level

  assign pin_raw = {power_save, hw_addr_bit_two, hw_addr_bit_one,
                    hw_addr_bit_zero, sda_in, scl};

  // the straps ride the same chain, so no address glitch lands
  pin_sync #(
    .WIDTH   (PIN_W),
    .STAGES  (SYNC_STAGES),
    .RST_VAL (PIN_RST)
  ) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      (pin_raw),
    .q      (pin_s)
  );

  assign ps = pin_s.saving;

  // previous levels for edge finding
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= pin_s.scl;
      sda_q_r <= pin_s.sda;
    end
  end

  // ***********************************************************
  // bus events
  // ***********************************************************

  logic       scl_rise;   // clock went high
  logic       scl_fall;   // clock went low
  logic       start_det;  // start seen
  logic       stop_det;   // stop seen
  logic       addr_hit;   // address byte names this device
  logic       rx_done;    // eighth bit over, ack slot opens
  logic       ack_end;    // ack slot over
  logic       bit_rise;   // a data bit is sampled
  logic       tx_fall;    // next transmit bit goes out

  bus_state_e state_r;    // bus sequencer
  logic [3:0] bit_cnt_r;  // bits taken in this byte
  logic       ack_r;      // inside the ack slot
  logic       mack_r;     // master pulled the ack low
  logic [7:0] shift_r;    // incoming bits, msb first
  logic [7:0] tx_r;       // byte being sent
  logic [7:0] word_addr_r;// internal word address
  logic       fetch_r;    // memory read this cycle
  logic       wr_ready;   // write buffer has room

  assign scl_rise = pin_s.scl && !scl_q_r;
  assign scl_fall = !pin_s.scl && scl_q_r;

  // data edges with clock held high are control, never data
  assign start_det = pin_s.scl && scl_q_r && sda_q_r && !pin_s.sda;
  assign stop_det  = pin_s.scl && scl_q_r && !sda_q_r && pin_s.sda;

  // type code above, strap levels below, direction bit ignored
  assign addr_hit = shift_r[7:1] == {DEV_TYPE, pin_s.hw_addr};

  assign rx_done  = scl_fall && !ack_r && bit_cnt_r == BYTE_BITS;
  assign ack_end  = scl_fall && ack_r;
  assign bit_rise = scl_rise && !ack_r && bit_cnt_r != BYTE_BITS;
  assign tx_fall  = scl_fall && !ack_r && bit_cnt_r != BYTE_BITS
                    && bit_cnt_r != 4'h0;

  // ***********************************************************
  // sequencer
  // ***********************************************************

  // start wins over everything but power saving
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= st_idle;
    end else if (ps) begin
      state_r <= st_idle;
    end else if (start_det) begin
      state_r <= st_addr;
    end else if (stop_det) begin
      state_r <= st_idle;
    end else if (rx_done) begin
      unique case (state_r)
        st_addr: begin
          // direction picks data phase; read skips word address
          if (!addr_hit) state_r <= st_ignore;
          else if (shift_r[0]) state_r <= st_rdata;
          else state_r <= st_word;
        end
        st_word: begin
          state_r <= st_wdata;
        end
        st_wdata: begin
          // full buffer: refuse and drop off the bus
          if (!wr_ready) state_r <= st_ignore;
        end
        default: begin
          // rdata, idle, ignore and illegal codes hold
          state_r <= state_r;
        end
      endcase
    end else if (ack_end && state_r == st_rdata && !mack_r) begin
      state_r <= st_ignore;
    end
  end

  // bit counter and ack slot; start, stop and ack end clear both, count stops at eight
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_r <= 4'h0;
      ack_r     <= 1'b0;
    end else if (ps || start_det || stop_det) begin
      bit_cnt_r <= 4'h0;
      ack_r     <= 1'b0;
    end else if (ack_end) begin
      bit_cnt_r <= 4'h0;
      ack_r     <= 1'b0;
    end else if (rx_done) begin
      ack_r     <= 1'b1;
    end else if (bit_rise) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  // incoming bits, sampled on the rising clock
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shift_r <= DATA_RST;
    end else if (bit_rise) begin
      shift_r <= {shift_r[6:0], pin_s.sda};
    end
  end

  // ack level; our own low ack reads back as continue
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mack_r <= 1'b0;
    end else if (scl_rise && ack_r) begin
      mack_r <= !pin_s.sda;
    end
  end

  // ***********************************************************
  // data line drive
  // ***********************************************************

  // changes after a falling clock, or on start, stop or power saving; otherwise held through high
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sda_oe_n <= 1'b1;
    end else if (ps || start_det || stop_det) begin
      sda_oe_n <= 1'b1;
    end else if (rx_done) begin
      unique case (state_r)
        st_addr:  sda_oe_n <= !addr_hit;
        st_word:  sda_oe_n <= 1'b0;
        st_wdata: sda_oe_n <= !wr_ready;
        default:  sda_oe_n <= 1'b1;
      endcase
    end else if (ack_end) begin
      if (state_r == st_rdata && mack_r) sda_oe_n <= tx_r[7];
      else sda_oe_n <= 1'b1;
    end else if (tx_fall && state_r == st_rdata) begin
      sda_oe_n <= tx_r[~bit_cnt_r[2:0]];
    end
  end

  // open drain: the driven level is always low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) sda_out <= 1'b0;
    else sda_out <= 1'b0;
  end

  // power-saving status for the system
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) saving <= 1'b0;
    else saving <= ps;
  end

  // ***********************************************************
  // word address and memory
  // ***********************************************************

  // address survives power saving; only bus logic is reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      word_addr_r <= ADDR_RST;
    end else if (ps || start_det) begin
      word_addr_r <= word_addr_r;
    end else if (rx_done && state_r == st_word) begin
      word_addr_r <= shift_r;
    end else if (rx_done && ((state_r == st_wdata && wr_ready)
                             || state_r == st_rdata)) begin
      word_addr_r <= word_addr_r + 8'h01;
    end
  end

  // read as the address ack slot opens, and after each byte sent
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) fetch_r <= 1'b0;
    else fetch_r <= rx_done && !ps && !start_det && !stop_det
                    && ((state_r == st_addr && addr_hit && shift_r[0])
                        || state_r == st_rdata);
  end

  wr_req_s    wr_in;      // write going into the buffer
  wr_req_s    wr_out;     // write leaving the buffer
  logic       wr_valid;   // buffer offers a write
  logic       drain_rdy;  // memory port free for a write
  logic       push;       // byte handed to the buffer

  assign push      = rx_done && state_r == st_wdata && !ps
                     && !start_det && !stop_det;
  assign wr_in     = '{addr: word_addr_r, data: shift_r};
  // reads own the single port; writes wait a cycle
  assign drain_rdy = !fetch_r;

  // bytes arrive far slower than they drain, so full is rare
  byte_fifo #(
    .WIDTH ($bits(wr_req_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (push),
    .in_ready  (wr_ready),
    .in_data   (wr_in),
    .out_valid (wr_valid),
    .out_ready (drain_rdy),
    .out_data  (wr_out)
  );

  logic [7:0] mem_r [MEM_DEPTH];  // storage, kept through resets

  // single port: a read or a buffered write each cycle
  always_ff @(posedge clk) begin
    if (wr_valid && drain_rdy) mem_r[wr_out.addr] <= wr_out.data;
  end

  // byte to send, fetched at the current word address
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) tx_r <= DATA_RST;
    else if (fetch_r) tx_r <= mem_r[word_addr_r];
  end

  // ***********************************************************
  // checks
  // ***********************************************************

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_start_abandon: assert property (
    start_det && !ps |=> state_r == st_addr && sda_oe_n && bit_cnt_r == 4'h0)
    else $error("start did not restart the address phase");

  a_stop_idle: assert property (
    stop_det && !start_det |=> state_r == st_idle && sda_oe_n)
    else $error("stop did not end the transfer");

  a_idle_released: assert property (
    state_r == st_idle || state_r == st_ignore |-> sda_oe_n)
    else $error("data line driven while not addressed");

  a_hold_high: assert property (
    pin_s.scl && scl_q_r && !$past(start_det) && !$past(stop_det)
    && !$past(ps) |-> $stable(sda_oe_n))
    else $error("data drive changed while clock high");

  a_addr_ack: assert property (
    rx_done && state_r == st_addr && addr_hit && !ps
    |=> !sda_oe_n && ack_r)
    else $error("matching address not acknowledged");

  a_miss_ignore: assert property (
    rx_done && state_r == st_addr && !addr_hit && !ps
    |=> state_r == st_ignore && sda_oe_n)
    else $error("mismatched address answered");

  a_word_load: assert property (
    rx_done && state_r == st_word && !ps && !start_det
    |=> word_addr_r == $past(shift_r) && state_r == st_wdata)
    else $error("word address not loaded");

  a_addr_step: assert property (
    rx_done && state_r == st_rdata && !ps && !start_det
    |=> word_addr_r == 8'($past(word_addr_r) + 8'h01) && fetch_r)
    else $error("word address did not advance before fetch");

  a_tx_release: assert property (
    rx_done && state_r == st_rdata && !ps && !start_det && !stop_det
    |=> sda_oe_n && ack_r)
    else $error("transmitter held data in master ack slot");

  a_nack_quit: assert property (
    ack_end && state_r == st_rdata && !mack_r && !ps && !start_det
    && !stop_det |=> state_r == st_ignore && sda_oe_n)
    else $error("device kept driving after nack");

  a_full_refuse: assert property (
    push && !wr_ready |=> sda_oe_n && state_r == st_ignore)
    else $error("byte acknowledged with buffer full");

  a_bit_bound: assert property (
    bit_cnt_r <= BYTE_BITS)
    else $error("bit counter beyond eight");

endmodule

`default_nettype wire

// ### bench/i2c_master_model.sv
// behavioural two-wire bus master that clocks the sram slave
`default_nettype none

module i2c_master_model (
  // system clock paces the serial clock
  input  wire logic clk,
  // resolved level of the data wire
  input  wire logic sda_wire,
  // master's drive toward the bus
  output logic      scl,
  output logic      sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;

  // quarter of one 160 ns serial period, in system clocks
  localparam int QTR = 8;

  // count of data wire changes seen while clock was high
  int unstable;

  // ************************************************************
  // bus primitives
  // ************************************************************
  // idle bus: clock high, data released to the pull-up
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
    unstable = 0;
  end

  // let n rising edges of the system clock pass
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one clock pulse; data set while low, wire sampled twice while high
  task automatic bit_io(input logic drive_low, output logic seen);
    wait_clk(QTR);
    sda_pull <= drive_low;
    wait_clk(QTR);
    scl <= 1'b1;
    wait_clk(1);
    #1 seen = sda_wire;
    wait_clk(QTR - 1);
    // a change here would be taken as a control condition
    if (sda_wire !== seen) begin
      unstable++;
    end
    wait_clk(QTR);
    scl <= 1'b0;
  endtask

  // start: data falls while clock is high; callers only use it on an idle bus
  // or as a deliberate repeated start
  task automatic bus_start();
    wait_clk(QTR);
    sda_pull <= 1'b0;
    wait_clk(QTR);
    scl <= 1'b1;
    wait_clk(QTR);
    sda_pull <= 1'b1;
    wait_clk(QTR);
    scl <= 1'b0;
  endtask

  // stop: data rises while clock is high, bus left idle
  task automatic bus_stop();
    wait_clk(QTR);
    sda_pull <= 1'b1;
    wait_clk(QTR);
    scl <= 1'b1;
    wait_clk(QTR);
    sda_pull <= 1'b0;
    wait_clk(QTR);
  endtask

  // eight bits msb first, then the acknowledge slot with data released
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(!b[i], s);
    end
    bit_io(1'b0, s);
    ack = !s;
  endtask

  // read eight bits, then acknowledge when more are wanted
  task automatic recv_byte(input logic more, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b0, s);
      b[i] = s;
    end
    bit_io(more, s);
  endtask
endmodule

`default_nettype wire

// ### bench/tb_top.sv
// self-checking bench for the two-wire sram slave port
`default_nettype none

module tb_top
  import i2c_sram_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // signals
  // ************************************************************
  logic       clk;         // 200 MHz system clock
  logic       resetn;      // async reset, active low
  logic       scl;         // serial clock from the master
  logic       sda_pull;    // master pulls data low
  logic       sda_wire;    // wired-and data level
  logic       sda_oe_n;    // slave drive enable, active low
  logic       sda_lvl;     // level the slave drives when enabled
  logic       power_save;  // power-saving pin
  logic       saving;      // slave's saving flag
  logic [2:0] straps;      // address strap levels
  int         num_errors;  // mismatches
  int         checks_done; // comparisons

  // pull-up unless either party pulls low; a wrong drive level loses the acks
  assign sda_wire = !sda_pull && (sda_oe_n || sda_lvl);

  // ************************************************************
  // instances
  // ************************************************************
  i2c_slave_sram_port dut_u (
    .clk              (clk),
    .resetn           (resetn),
    .scl              (scl),
    .sda_in           (sda_wire),
    .sda_out          (sda_lvl),
    .sda_oe_n         (sda_oe_n),
    .hw_addr_bit_zero (straps[0]),
    .hw_addr_bit_one  (straps[1]),
    .hw_addr_bit_two  (straps[2]),
    .power_save       (power_save),
    .saving           (saving)
  );

  i2c_master_model master_u (
    .clk      (clk),
    .sda_wire (sda_wire),
    .scl      (scl),
    .sda_pull (sda_pull)
  );

  // free-running system clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ************************************************************
  // helpers
  // ************************************************************
  // slave address byte: type code, straps, direction
  function automatic logic [7:0] addr_byte(input logic [2:0] a, input logic rd);
    return {DEV_TYPE, a, rd};
  endfunction

  // compare and report
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // counts, verdict, end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // bounded wait for the saving flag to reach a level
  task automatic wait_saving(input logic lvl);
    int n;
    n = 0;
    while (saving !== lvl && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(8'(saving), 8'(lvl), "saving flag");
    if (n >= 50) begin
      stop_test();
    end
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  // five data bytes from 0xfe, so the address wraps past the top
  task automatic write_wrap();
    logic ack;
    master_u.bus_start();
    master_u.send_byte(addr_byte(straps, 1'b0), ack);
    check(8'(ack), 8'h01, "address ack");
    master_u.send_byte(8'hfe, ack);
    check(8'(ack), 8'h01, "word address ack");
    for (int i = 0; i < 5; i++) begin
      master_u.send_byte(8'h50 + 8'(i), ack);
      check(8'(ack), 8'h01, "data ack");
    end
    master_u.bus_stop();
  endtask

  // set address, repeated start, read three bytes across the wrap
  task automatic read_random();
    logic       ack;
    logic [7:0] b;
    master_u.bus_start();
    master_u.send_byte(addr_byte(straps, 1'b0), ack);
    master_u.send_byte(8'hfe, ack);
    master_u.bus_start();
    master_u.send_byte(addr_byte(straps, 1'b1), ack);
    check(8'(ack), 8'h01, "read address ack after restart");
    for (int i = 0; i < 3; i++) begin
      master_u.recv_byte(i < 2, b);
      check(b, 8'h50 + 8'(i), "sequential read data");
    end
    // after the master's refusal the slave must stay off the wire
    master_u.wait_clk(8);
    #1 check(8'(sda_oe_n), 8'h01, "release after refusal");
    master_u.bus_stop();
  endtask

  // read straight after the address byte, from the current address
  task automatic read_current(input logic [7:0] exp);
    logic       ack;
    logic [7:0] b;
    master_u.bus_start();
    master_u.send_byte(addr_byte(straps, 1'b1), ack);
    check(8'(ack), 8'h01, "current read ack");
    master_u.recv_byte(1'b0, b);
    check(b, exp, "current address data");
    master_u.bus_stop();
  endtask

  // every strap value: own address answers, another does not
  task automatic strap_select();
    logic ack;
    for (int a = 0; a < 8; a++) begin
      straps <= 3'(a);
      master_u.wait_clk(4);
      master_u.bus_start();
      master_u.send_byte(addr_byte(3'(a), 1'b0), ack);
      check(8'(ack), 8'h01, "own strap address");
      master_u.bus_stop();
      master_u.bus_start();
      master_u.send_byte(addr_byte(~3'(a), 1'b0), ack);
      check(8'(ack), 8'h00, "foreign address");
      master_u.send_byte(8'h00, ack);
      check(8'(ack), 8'h00, "ignored after mismatch");
      master_u.bus_stop();
    end
    straps <= 3'h5;
  endtask

  // power saving mid-transfer silences the bus logic, word address kept
  task automatic power_cut();
    logic ack;
    master_u.bus_start();
    master_u.send_byte(addr_byte(straps, 1'b0), ack);
    power_save <= 1'b1;
    wait_saving(1'b1);
    master_u.send_byte(8'h40, ack);
    check(8'(ack), 8'h00, "silent while saving");
    power_save <= 1'b0;
    wait_saving(1'b0);
    master_u.send_byte(8'h41, ack);
    check(8'(ack), 8'h00, "bus logic reset");
    master_u.bus_stop();
    read_current(8'h54);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    resetn      = 1'b0;
    power_save  = 1'b0;
    straps      = 3'h5;
    num_errors  = 0;
    checks_done = 0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    #1 check(8'(sda_oe_n), 8'h01, "idle released");
    write_wrap();
    read_random();
    read_current(8'h53);
    strap_select();
    power_cut();
    check(8'(master_u.unstable), 8'h00, "data steady while clock high");
    stop_test();
  end

  // hang guard
  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    $display("Error at %0t ns: run did not finish", $time);
    stop_test();
  end
endmodule

`default_nettype wire
